// ===== rtl/hdrdc_consts.svh
/*
 Constants for the half-duplex repeater direction control.
 Assumes a 25 MHz system clock; times are in ns.
*/
`ifndef HDRDC_CONSTS_SVH
`define HDRDC_CONSTS_SVH

`define HDRDC_CLK_PERIOD_NS 40
// ----------------------------------------
// Timing
// ----------------------------------------
`define HDRDC_DRIVER_RISE_LATENCY_MAX_NS 2000
`define HDRDC_HOLD_MARGIN_PCT 130
`define HDRDC_HOLD_NS ((`HDRDC_DRIVER_RISE_LATENCY_MAX_NS * `HDRDC_HOLD_MARGIN_PCT + 99) / 100)
`define HDRDC_HOLD_CYCLES ((`HDRDC_HOLD_NS + `HDRDC_CLK_PERIOD_NS - 1) / `HDRDC_CLK_PERIOD_NS)
`define HDRDC_ONESHOT_NS 10000000
`define HDRDC_ONESHOT_CYCLES ((`HDRDC_ONESHOT_NS + `HDRDC_CLK_PERIOD_NS - 1) / `HDRDC_CLK_PERIOD_NS)
`define HDRDC_CNT_W 24

`endif

// ===== rtl/hdrdc_pkg.sv
/*
 Types for the half-duplex repeater direction control.
 Assumes hdrdc_consts.svh is available on the include path.
*/
`include "hdrdc_consts.svh"

package hdrdc_pkg;

    typedef enum logic [2:0] {
        HDRDC_IDLE = 3'b001,
        HDRDC_A2B = 3'b010,
        HDRDC_B2A = 3'b100
    } hdrdc_dir_e;

    // One segment's transceiver controls
    typedef struct packed {
        logic drv_en;
        logic drv_data;
        logic rx_en;
    } hdrdc_seg_s;

endpackage : hdrdc_pkg

// ===== rtl/hdrdc_sync.sv
/*
 Two-flop synchroniser for one receive line, with fall detect.
 Assumes the input is asynchronous; resets to the idle (high) level.
*/
`timescale 1ns/100ps
`default_nettype none

module hdrdc_sync (
    input wire logic clk,
    input wire logic rst,
    input wire logic async_in,
    output logic level,
    output logic fell
);

    logic meta;
    logic prev;

    always_ff @(posedge clk) begin
        if (rst) begin
            meta <= 1'b1;
            level <= 1'b1;
        end else begin
            meta <= async_in;
            level <= meta;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            prev <= 1'b1;
        end else begin
            prev <= level;
        end
    end

    assign fell = prev & ~level;

endmodule : hdrdc_sync

`default_nettype wire

// ===== rtl/hdrdc_ctrl.sv
/*
 Direction control for a half-duplex repeater joining segment A and B.
 Assumes each segment has a transceiver with receive output, driver enable,
 driver data and receiver enable; receive outputs idle high by fail-safe bias.
*/
// How it works
// - Idle with both lines high: receive only
// - First segment receiving decides forwarding direction
// - One-shot: receive fall fires driver pulse
// - One-shot pulse spans the whole packet
// - Own driven side's receive read as high
// - Per-bit: drive low bits in full, high bits only for the hold
// - Per-bit: low enables opposite driver at once
// - Receive high: drive high, hold, then release
// - Hold exceeds driver rise latency by 30%
// - Drive valid high before returning to receive
// - Undriven for rest of high bit, idle
`timescale 1ns/100ps
`default_nettype none

module hdrdc_ctrl
    import hdrdc_pkg::*;
#(
    parameter int unsigned CNT_W = `HDRDC_CNT_W,
    parameter int unsigned HOLD_CYCLES = `HDRDC_HOLD_CYCLES,
    parameter int unsigned ONESHOT_CYCLES = `HDRDC_ONESHOT_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic mode_per_bit,
    input wire logic port_a_rx,
    input wire logic port_b_rx,
    output hdrdc_seg_s port_a_ctrl,
    output hdrdc_seg_s port_b_ctrl,
    output logic port_b_line_driver,
    output hdrdc_dir_e direction
);

    logic a_lvl, a_fell, b_lvl, b_fell;
    logic mode_meta, mode;
    hdrdc_dir_e dir, next_dir;
    logic [CNT_W-1:0] cnt, next_cnt;
    logic drive_low, next_drive_low;

    // A zero count would release at once or never expire; treat it as one clock
    function automatic logic [CNT_W-1:0] cycles_of(input int unsigned n);
        cycles_of = (n == 0) ? CNT_W'(1) : CNT_W'(n);
    endfunction : cycles_of

    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    // Both lines reset to their idle high, so no false fall follows reset
    hdrdc_sync u_sync_a (
        .clk(clk),
        .rst(rst),
        .async_in(port_a_rx),
        .level(a_lvl),
        .fell(a_fell)
    );

    hdrdc_sync u_sync_b (
        .clk(clk),
        .rst(rst),
        .async_in(port_b_rx),
        .level(b_lvl),
        .fell(b_fell)
    );

    // Mode strap is a pin too, so it is synchronised like the lines
    // A mode change takes effect at once, even inside a packet
    always_ff @(posedge clk) begin
        if (rst) begin
            mode_meta <= 1'b0;
            mode <= 1'b0;
        end else begin
            mode_meta <= mode_per_bit;
            mode <= mode_meta;
        end
    end

    // ----------------------------------------
    // Direction and timing
    // ----------------------------------------
    // Source line of the active direction; idle reads as a quiet high
    logic src_lvl, src_fell;
    always_comb begin
        src_lvl = 1'b1;
        src_fell = 1'b0;
        case (dir)
            HDRDC_A2B: begin
                src_lvl = a_lvl;
                src_fell = a_fell;
            end
            HDRDC_B2A: begin
                src_lvl = b_lvl;
                src_fell = b_fell;
            end
            default: begin
                src_lvl = 1'b1;
                src_fell = 1'b0;
            end
        endcase
    end

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    // A low lasting longer than the one-shot lets the pulse expire with the
    // source still low; the driver drops for one clock and then re-arms,
    // so the one-shot length must outlast the longest gap between falls.
    always_comb begin
        next_dir = dir;
        next_cnt = cnt;
        next_drive_low = drive_low;
        case (dir)
            HDRDC_IDLE: begin
                next_drive_low = 1'b0;
                next_cnt = '0;
                // Per-bit starts with no count; one-shot starts its pulse
                // A wins a same-cycle tie so only one direction opens
                if (!a_lvl) begin
                    next_dir = HDRDC_A2B;
                    next_drive_low = 1'b1;
                    next_cnt = mode ? '0 : cycles_of(ONESHOT_CYCLES);
                end else if (!b_lvl) begin
                    next_dir = HDRDC_B2A;
                    next_drive_low = 1'b1;
                    next_cnt = mode ? '0 : cycles_of(ONESHOT_CYCLES);
                end
            end
            HDRDC_A2B, HDRDC_B2A: begin
                // The reverse line is never read here, so nothing turns until the next return to idle
                if (mode) begin
                    // Per-bit: the far receive line is ignored here, which
                    // keeps the direction locked while we drive it
                    if (!src_lvl) begin
                        next_drive_low = 1'b1;
                        next_cnt = '0;
                    end else if (drive_low) begin
                        next_drive_low = 1'b0;
                        next_cnt = cycles_of(HOLD_CYCLES);
                    end else if (cnt > CNT_W'(1)) begin
                        next_cnt = cnt - CNT_W'(1);
                    end else begin
                        next_cnt = '0;
                        next_dir = HDRDC_IDLE;
                    end
                end else begin
                    // One-shot: the line is forwarded as is; every falling
                    // edge re-arms the pulse
                    next_drive_low = ~src_lvl;
                    if (src_fell) begin
                        next_cnt = cycles_of(ONESHOT_CYCLES);
                    end else if (cnt > CNT_W'(1)) begin
                        next_cnt = cnt - CNT_W'(1);
                    end else begin
                        next_cnt = '0;
                        next_dir = HDRDC_IDLE;
                        next_drive_low = 1'b0;
                    end
                end
            end
            default: begin
                next_dir = HDRDC_IDLE;
                next_cnt = '0;
                next_drive_low = 1'b0;
            end
        endcase
    end

    // ----------------------------------------
    // State registers
    // ----------------------------------------
    // Direction, counter and data phase each keep their own register
    always_ff @(posedge clk) begin
        if (rst) begin
            dir <= HDRDC_IDLE;
        end else begin
            dir <= next_dir;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cnt <= '0;
            drive_low <= 1'b0;
        end else begin
            cnt <= next_cnt;
            drive_low <= next_drive_low;
        end
    end

    // ----------------------------------------
    // Transceiver outputs, all registered
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            port_a_ctrl <= '{drv_en: 1'b0, drv_data: 1'b1, rx_en: 1'b1};
            port_b_ctrl <= '{drv_en: 1'b0, drv_data: 1'b1, rx_en: 1'b1};
            port_b_line_driver <= 1'b0;
            direction <= HDRDC_IDLE;
        end else begin
            // Pins follow the source three clocks late: two sync flops and this one
            // Drive data rests high whenever no low bit is being forwarded
            // Only one direction state exists, so both drivers can't be on
            port_b_ctrl.drv_en <= (next_dir == HDRDC_A2B);
            port_a_ctrl.drv_en <= (next_dir == HDRDC_B2A);
            port_b_line_driver <= (next_dir == HDRDC_A2B);
            // Driving side's receiver is disabled and seen as high
            port_b_ctrl.rx_en <= (next_dir != HDRDC_A2B);
            port_a_ctrl.rx_en <= (next_dir != HDRDC_B2A);
            port_b_ctrl.drv_data <= ~(next_dir == HDRDC_A2B && next_drive_low);
            port_a_ctrl.drv_data <= ~(next_dir == HDRDC_B2A && next_drive_low);
            direction <= next_dir;
        end
    end

endmodule : hdrdc_ctrl

`default_nettype wire

// ===== tb/hdrdc_ctrl_assertions.sv
/* Port checker for hdrdc_ctrl.
   Assumes it is bound into hdrdc_ctrl. */
`timescale 1ns/100ps
`default_nettype none
module hdrdc_ctrl_chk
    import hdrdc_pkg::*;
#(parameter int unsigned HOLD_CYCLES = 4, parameter int unsigned ONESHOT_CYCLES = 50) (
    input wire logic clk,
    input wire logic rst,
    input wire logic mode_per_bit,
    input wire logic port_a_rx,
    input wire logic port_b_rx,
    input wire hdrdc_seg_s port_a_ctrl,
    input wire hdrdc_seg_s port_b_ctrl,
    input wire logic port_b_line_driver,
    input wire hdrdc_dir_e direction
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // ----------------
    // Quiet counters
    // ----------------
    logic [31:0] quiet;
    logic [31:0] high;
    always_ff @(posedge clk) begin
        quiet <= (rst || $fell(port_a_rx) || $fell(port_b_rx)) ? '0 : quiet + 1;
    end
    always_ff @(posedge clk) begin
        high <= (rst || !port_a_rx || !port_b_rx || !mode_per_bit) ? '0 : high + 1;
    end
    sequence s_a_start;
        direction == HDRDC_IDLE && $fell(port_a_rx) && port_b_rx ##1 (!port_a_rx && port_b_rx) [*3];
    endsequence
    sequence s_a_rise;
        mode_per_bit && direction == HDRDC_A2B && $rose(port_a_rx) ##1 (mode_per_bit && port_a_rx) [*2];
    endsequence
    chk_start_fwd: assert property (s_a_start |-> ##[0:1] port_b_ctrl.drv_en)
        else $error("no forward start");
    chk_rise_high: assert property (s_a_rise |=> port_b_ctrl.drv_en && port_b_ctrl.drv_data)
        else $error("no driven high");
    chk_hold_len: assert property ($rose(port_b_ctrl.drv_data) && port_b_ctrl.drv_en && mode_per_bit
        |-> port_b_ctrl.drv_en [*3]) else $error("hold too short");
    chk_no_both: assert property (!(port_a_ctrl.drv_en && port_b_ctrl.drv_en))
        else $error("both drivers on");
    chk_idle_rx: assert property (direction == HDRDC_IDLE |-> port_a_ctrl.rx_en && port_b_ctrl.rx_en
        && !port_a_ctrl.drv_en && !port_b_ctrl.drv_en) else $error("idle not receiving");
    chk_b_follow: assert property (port_b_line_driver == port_b_ctrl.drv_en
        && port_b_ctrl.rx_en != port_b_ctrl.drv_en) else $error("b controls mismatch");
    chk_bit_release: assert property (high == HOLD_CYCLES + 6 |-> direction == HDRDC_IDLE)
        else $error("no release");
    chk_os_span: assert property ($fell(port_b_ctrl.drv_en) && !mode_per_bit |-> quiet >= ONESHOT_CYCLES)
        else $error("pulse too short");
endmodule : hdrdc_ctrl_chk
bind hdrdc_ctrl hdrdc_ctrl_chk #(.HOLD_CYCLES(HOLD_CYCLES), .ONESHOT_CYCLES(ONESHOT_CYCLES)) chk_i (.clk, .rst,
    .mode_per_bit, .port_a_rx, .port_b_rx, .port_a_ctrl, .port_b_ctrl, .port_b_line_driver, .direction);
`default_nettype wire

// ===== tb/hdrdc_xcvr_model.sv
/* One segment's transceiver and bus.
   Assumes the remote node sends far_level only while the repeater listens. */
`timescale 1ns/100ps
`default_nettype none
module hdrdc_xcvr_model
    import hdrdc_pkg::*;
(
    input wire hdrdc_seg_s ctrl,
    input wire logic far_level,
    output logic rx,
    output logic bus_level
);
    // ----------------
    // Bus and receiver
    // ----------------
    // Released bus follows the remote node's far_level, not the last driven level
    assign bus_level = ctrl.drv_en ? ctrl.drv_data : far_level;
    // Pull-up on a disabled receiver keeps the reverse path quiet
    assign rx = (ctrl.drv_en || !ctrl.rx_en) ? 1'b1 : far_level;
endmodule : hdrdc_xcvr_model
`default_nettype wire

// ===== tb/tb.sv
/* Self-checking bench for hdrdc_ctrl.
   Assumes hdrdc_xcvr_model stands on both segments. */
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin errors++; $display("Error at %0t: %h %h", $time, a, e); end end
module tb;
    import hdrdc_pkg::*;
    localparam int HOLD = 4;
    localparam int OS = 50;
    logic clk = 0, rst = 1, mode = 1, far_a = 1, far_b = 1;
    logic rx_a, rx_b, bus_a, bus_b, line_drv;
    logic [3:0] h = '1;
    hdrdc_seg_s ctl_a, ctl_b;
    hdrdc_dir_e dir;
    int errors = 0, checks = 0, seed = 63873;
    hdrdc_ctrl #(.HOLD_CYCLES(HOLD), .ONESHOT_CYCLES(OS)) hdrdc_ctrl_i (.clk, .rst, .mode_per_bit(mode),
        .port_a_rx(rx_a), .port_b_rx(rx_b), .port_a_ctrl(ctl_a), .port_b_ctrl(ctl_b),
        .port_b_line_driver(line_drv), .direction(dir));
    hdrdc_xcvr_model seg_a_i (.ctrl(ctl_a), .far_level(far_a), .rx(rx_a), .bus_level(bus_a));
    hdrdc_xcvr_model seg_b_i (.ctrl(ctl_b), .far_level(far_b), .rx(rx_b), .bus_level(bus_b));
    initial forever #20 clk = ~clk;
    initial begin
        #4000000;
        errors++;
        stop_test();
    end
    task automatic stop_test();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : stop_test
    // ----------------
    // Traffic
    // ----------------
    // Far bus repeats the source three edges late: two sync flops and the output register
    function automatic logic lagged(input logic [3:0] hist);
        return hist[3];
    endfunction : lagged
    // Far bus must follow the source, checked once per clock just after the edge
    task automatic step(input bit b2a, input logic v);
        @(posedge clk);
        #1;
        if (b2a) far_b = v;
        else far_a = v;
        h = {h[2:0], v};
        `CHK(b2a ? bus_a : bus_b, lagged(h))
    endtask : step
    task automatic frame(input bit b2a, input int n, input int tail);
        int len;
        logic v;
        for (int i = 0; i < n; i++) begin
            v = (i == 0) ? 1'b0 : 1'($random(seed));
            len = (i == 0) ? 6 : 1 + {$random(seed)} % 12;
            repeat (len) step(b2a, v);
            if (i == 0) `CHK(dir, b2a ? HDRDC_B2A : HDRDC_A2B)
            if (i == 0) `CHK(b2a ? ctl_a.rx_en : ctl_b.rx_en, 1'b0)
        end
        repeat (tail) step(b2a, 1'b1);
        `CHK(dir, HDRDC_IDLE)
    endtask : frame
    initial begin
        repeat (10) @(posedge clk);
        #1 rst = 0;
        repeat (4) step(0, 1'b1);
        `CHK({ctl_a.drv_en, ctl_b.drv_en, ctl_a.rx_en, ctl_b.rx_en}, 4'h3)
        frame(0, 16, HOLD + 12);
        frame(1, 16, HOLD + 12);
        $display("test per_bit done");
        @(posedge clk);
        #1 {far_a, far_b} = 2'b00;
        repeat (6) @(posedge clk);
        #1 `CHK(dir, HDRDC_A2B)
        `CHK(ctl_a.drv_en, 1'b0)
        {far_a, far_b} = 2'b11;
        h = 4'h1;
        repeat (HOLD + 12) step(0, 1'b1);
        `CHK(dir, HDRDC_IDLE)
        $display("test tie done");
        mode = 0;
        repeat (4) step(0, 1'b1);
        repeat (3) step(0, 1'b0);
        repeat (OS - 6) step(0, 1'b1);
        `CHK(ctl_b.drv_en, 1'b1)
        repeat (20) step(0, 1'b1);
        `CHK(dir, HDRDC_IDLE)
        // Four bits keep every packet shorter than the one-shot pulse
        frame(0, 4, OS + 12);
        $display("test one_shot done");
        mode = 1;
        repeat (6) step(0, 1'b0);
        rst = 1;
        @(posedge clk);
        #1 `CHK(ctl_b.drv_en, 1'b0)
        far_a = 1;
        h = '1;
        repeat (2) @(posedge clk);
        #1 rst = 0;
        repeat (6) step(0, 1'b1);
        `CHK(dir, HDRDC_IDLE)
        $display("test reset done");
        stop_test();
    end
endmodule : tb
`default_nettype wire
